// [obd_pkg.sv]
// Purpose: constants shared by the option byte decoder
// Assumes: option bytes sit at consecutive byte offsets from the option area base
// Notes:   offsets are the low bits of the option area addresses
package obd_pkg;

   // option area layout, byte offsets from the base
   localparam logic [3:0] OFS_READOUT_LOCK      = 4'h0;
   localparam logic [3:0] OFS_BOOT_AREA_SIZE    = 4'h1;
   localparam logic [3:0] OFS_BOOT_AREA_COMP    = 4'h2;
   localparam logic [3:0] OFS_PIN_REMAP         = 4'h3;
   localparam logic [3:0] OFS_PIN_REMAP_COMP    = 4'h4;
   localparam logic [3:0] OFS_MISC_CONFIG       = 4'h5;
   localparam logic [3:0] OFS_MISC_CONFIG_COMP  = 4'h6;
   localparam logic [3:0] OFS_CLOCK_CONFIG      = 4'h7;
   localparam logic [3:0] OFS_CLOCK_CONFIG_COMP = 4'h8;
   localparam logic [3:0] OFS_SETTLE_COUNT      = 4'h9;
   localparam logic [3:0] OFS_SETTLE_COUNT_COMP = 4'hA;
   localparam int         NUM_BYTES             = 11;

   // factory values of plain and complemented bytes
   localparam logic [7:0] RESET_PLAIN = 8'h00;
   localparam logic [7:0] RESET_COMP  = 8'hFF;

   // read-out lock enabling code
   localparam logic [7:0] READOUT_LOCK_CODE = 8'hAA;

   // boot area decode
   localparam logic [7:0] BOOT_NONE      = 8'h00;
   localparam logic [7:0] BOOT_MAX_CODE  = 8'h7F;
   localparam logic [7:0] BOOT_ALL_PAGES = 8'h80;
   localparam logic [7:0] VECTOR_PAGES   = 8'h02;

   // misc config bit positions
   localparam int BIT_TRIM_SIZE   = 4;
   localparam int BIT_SLOW_RC_EN  = 3;
   localparam int BIT_INDEP_WD_HW = 2;
   localparam int BIT_WIN_WD_HW   = 1;
   localparam int BIT_WIN_WD_HALT = 0;

   // clock config bit positions
   localparam int BIT_EXT_CLK     = 3;
   localparam int BIT_WAKEUP_SEL  = 2;
   localparam int BIT_PRESC_HI    = 1;
   localparam int BIT_PRESC_LO    = 0;

   // wakeup prescaler expected input, in MHz
   localparam logic [4:0] WAKEUP_IN_16MHZ = 5'h10;
   localparam logic [4:0] WAKEUP_IN_8MHZ  = 5'h08;
   localparam logic [4:0] WAKEUP_IN_4MHZ  = 5'h04;

   // settle count codes and their waits in half oscillator cycles
   localparam logic [7:0]  SETTLE_CODE_2048 = 8'h00;
   localparam logic [7:0]  SETTLE_CODE_128  = 8'hB4;
   localparam logic [7:0]  SETTLE_CODE_8    = 8'hD2;
   localparam logic [7:0]  SETTLE_CODE_HALF = 8'hE1;
   localparam logic [12:0] SETTLE_HALF_2048 = 13'h1000;
   localparam logic [12:0] SETTLE_HALF_128  = 13'h0100;
   localparam logic [12:0] SETTLE_HALF_8    = 13'h0010;
   localparam logic [12:0] SETTLE_HALF_HALF = 13'h0001;

endpackage : obd_pkg

// [obd_option_decoder.sv]
// Purpose: option byte store and decoder for device-wide configuration
// Assumes: byte port is synchronous to mclk; one write or read per cycle
// Notes:   decoded settings are registered; a bad pair falls back to factory values
`timescale 1ns/1ps
`default_nettype none

module obd_option_decoder (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // option byte access port
   input  wire logic [3:0]  opt_addr,
   input  wire logic [7:0]  opt_wdata,
   input  wire logic        opt_we,
   input  wire logic        opt_from_debug,
   output logic      [7:0]  opt_rdata,
   // halt reset inputs
   input  wire logic        halt_entry,
   input  wire logic        window_watchdog_active,
   // decoded settings
   output logic             readout_lock,
   output logic      [7:0]  boot_code_area,
   output logic             vectors_protected,
   output logic             fast_rc_trim_size,
   output logic             slow_rc_cpu_enable,
   output logic             indep_watchdog_hw_start,
   output logic             window_watchdog_hw_start,
   output logic             window_watchdog_halt_reset,
   output logic             halt_reset,
   output logic             external_clock_select,
   output logic             wakeup_clock_select,
   output logic      [4:0]  wakeup_input_mhz,
   output logic      [12:0] osc_settle_half_cycles,
   output logic      [4:0]  config_error
);

   typedef struct packed {
      logic [obd_pkg::NUM_BYTES-1:0][7:0] mem;
      logic [7:0]  rdata;
      logic        lock;
      logic [7:0]  boot_pages;
      logic        vec_prot;
      logic        trim4;
      logic        slow_en;
      logic        iwd_hw;
      logic        wwd_hw;
      logic        halt_en;
      logic        halt_rst;
      logic        ext_clk;
      logic        wake_sel;
      logic [4:0]  wake_mhz;
      logic [12:0] settle;
      logic [4:0]  err;
   } obd_state_s;

   obd_state_s s;
   obd_state_s next_s;
   logic       protected_addr;
   logic [7:0] misc_eff;
   logic [7:0] clk_eff;
   logic [7:0] boot_eff;
   logic [7:0] settle_eff;

   // lock and boot bytes only change through the programming port
   assign protected_addr = (opt_addr == obd_pkg::OFS_READOUT_LOCK) ||
                           (opt_addr == obd_pkg::OFS_BOOT_AREA_SIZE) ||
                           (opt_addr == obd_pkg::OFS_BOOT_AREA_COMP);

   // next state: store, compare pairs, decode
   always_comb begin
      next_s = s;
      next_s.halt_rst = 1'b0;
      if (opt_we && (opt_addr < 4'(obd_pkg::NUM_BYTES)) && (opt_from_debug || !protected_addr)) begin
         next_s.mem[opt_addr] = opt_wdata;
      end
      if (!opt_we && (opt_addr < 4'(obd_pkg::NUM_BYTES))) begin
         next_s.rdata = s.mem[opt_addr];
      end else begin
         next_s.rdata = 8'h00; // unmapped or write cycle reads zero
      end
      // pair checks: plain byte must equal complement of its copy
      for (int i = 0; i < 5; i++) begin
         next_s.err[i] = (next_s.mem[2*i+1] != ~next_s.mem[2*i+2]);
      end
      // a failing pair decodes as its factory value, not the bad one
      boot_eff   = next_s.err[0] ? obd_pkg::RESET_PLAIN : next_s.mem[obd_pkg::OFS_BOOT_AREA_SIZE];
      misc_eff   = next_s.err[2] ? obd_pkg::RESET_PLAIN : next_s.mem[obd_pkg::OFS_MISC_CONFIG];
      clk_eff    = next_s.err[3] ? obd_pkg::RESET_PLAIN : next_s.mem[obd_pkg::OFS_CLOCK_CONFIG];
      settle_eff = next_s.err[4] ? obd_pkg::RESET_PLAIN : next_s.mem[obd_pkg::OFS_SETTLE_COUNT];
      // lock has no copy; anything but the code leaves reads open
      next_s.lock = (next_s.mem[obd_pkg::OFS_READOUT_LOCK] == obd_pkg::READOUT_LOCK_CODE);
      // boot area page count
      if (boot_eff == obd_pkg::BOOT_NONE) begin
         next_s.boot_pages = 8'h00;
      end else if (boot_eff <= obd_pkg::BOOT_MAX_CODE) begin
         next_s.boot_pages = boot_eff;
      end else begin
         next_s.boot_pages = obd_pkg::BOOT_ALL_PAGES;
      end
      next_s.vec_prot = (next_s.boot_pages >= obd_pkg::VECTOR_PAGES);
      // misc settings
      next_s.trim4   = misc_eff[obd_pkg::BIT_TRIM_SIZE];
      next_s.slow_en = misc_eff[obd_pkg::BIT_SLOW_RC_EN];
      next_s.iwd_hw  = misc_eff[obd_pkg::BIT_INDEP_WD_HW];
      next_s.wwd_hw  = misc_eff[obd_pkg::BIT_WIN_WD_HW];
      next_s.halt_en = misc_eff[obd_pkg::BIT_WIN_WD_HALT];
      // halt reset uses the setting already applied
      next_s.halt_rst = halt_entry && window_watchdog_active && s.halt_en;
      // clock settings
      next_s.ext_clk  = clk_eff[obd_pkg::BIT_EXT_CLK];
      next_s.wake_sel = clk_eff[obd_pkg::BIT_WAKEUP_SEL];
      if (!clk_eff[obd_pkg::BIT_PRESC_HI]) begin
         next_s.wake_mhz = obd_pkg::WAKEUP_IN_16MHZ;
      end else if (!clk_eff[obd_pkg::BIT_PRESC_LO]) begin
         next_s.wake_mhz = obd_pkg::WAKEUP_IN_8MHZ;
      end else begin
         next_s.wake_mhz = obd_pkg::WAKEUP_IN_4MHZ;
      end
      // settle wait; undefined codes take the longest, safest wait
      if (settle_eff == obd_pkg::SETTLE_CODE_128) begin
         next_s.settle = obd_pkg::SETTLE_HALF_128;
      end else if (settle_eff == obd_pkg::SETTLE_CODE_8) begin
         next_s.settle = obd_pkg::SETTLE_HALF_8;
      end else if (settle_eff == obd_pkg::SETTLE_CODE_HALF) begin
         next_s.settle = obd_pkg::SETTLE_HALF_HALF;
      end else begin
         next_s.settle = obd_pkg::SETTLE_HALF_2048;
      end
   end

   // state register, factory contents after reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         s            <= '0;
         s.mem[obd_pkg::OFS_BOOT_AREA_COMP]    <= obd_pkg::RESET_COMP;
         s.mem[obd_pkg::OFS_PIN_REMAP_COMP]    <= obd_pkg::RESET_COMP;
         s.mem[obd_pkg::OFS_MISC_CONFIG_COMP]  <= obd_pkg::RESET_COMP;
         s.mem[obd_pkg::OFS_CLOCK_CONFIG_COMP] <= obd_pkg::RESET_COMP;
         s.mem[obd_pkg::OFS_SETTLE_COUNT_COMP] <= obd_pkg::RESET_COMP;
         s.wake_mhz   <= obd_pkg::WAKEUP_IN_16MHZ;
         s.settle     <= obd_pkg::SETTLE_HALF_2048;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign opt_rdata                  = s.rdata;
   assign readout_lock               = s.lock;
   assign boot_code_area             = s.boot_pages;
   assign vectors_protected          = s.vec_prot;
   assign fast_rc_trim_size          = s.trim4;
   assign slow_rc_cpu_enable         = s.slow_en;
   assign indep_watchdog_hw_start    = s.iwd_hw;
   assign window_watchdog_hw_start   = s.wwd_hw;
   assign window_watchdog_halt_reset = s.halt_en;
   assign halt_reset                 = s.halt_rst;
   assign external_clock_select      = s.ext_clk;
   assign wakeup_clock_select        = s.wake_sel;
   assign wakeup_input_mhz           = s.wake_mhz;
   assign osc_settle_half_cycles     = s.settle;
   assign config_error               = s.err;

   // checks
   sequence lock_code_written;
      opt_we && opt_from_debug && (opt_addr == obd_pkg::OFS_READOUT_LOCK) && (opt_wdata == obd_pkg::READOUT_LOCK_CODE);
   endsequence

   sequence app_protected_write;
      opt_we && !opt_from_debug && protected_addr;
   endsequence

   a_lock_enable: assert property (@(posedge mclk) disable iff (reset)
      lock_code_written |=> readout_lock ##1 (readout_lock || $past(opt_we)))
      else $error("lock code did not enable protection");

   a_lock_other: assert property (@(posedge mclk) disable iff (reset)
      (opt_we && (opt_addr == obd_pkg::OFS_READOUT_LOCK) && opt_from_debug && (opt_wdata != obd_pkg::READOUT_LOCK_CODE))
      |=> !readout_lock)
      else $error("non-code lock value enabled protection");

   a_app_blocked: assert property (@(posedge mclk) disable iff (reset)
      app_protected_write |=> ($stable(readout_lock) && $stable(boot_code_area)))
      else $error("application changed lock or boot area");

   a_boot_none: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && (s.mem[1] == obd_pkg::BOOT_NONE) && (s.mem[2] == obd_pkg::RESET_COMP)) |=> (boot_code_area == 8'h00))
      else $error("zero boot byte gave pages");

   a_boot_range: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[0] && (s.mem[1] <= obd_pkg::BOOT_MAX_CODE)) |=> (boot_code_area == $past(s.mem[1])))
      else $error("boot page count wrong");

   a_boot_full: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[0] && (s.mem[1] > obd_pkg::BOOT_MAX_CODE)) |=> (boot_code_area == obd_pkg::BOOT_ALL_PAGES))
      else $error("large boot byte did not cover all pages");

   a_vector_prot: assert property (@(posedge mclk) disable iff (reset)
      vectors_protected == (boot_code_area >= obd_pkg::VECTOR_PAGES))
      else $error("vector protection disagrees with boot area");

   a_halt_reset: assert property (@(posedge mclk) disable iff (reset)
      (halt_entry && window_watchdog_active) |=> (halt_reset == $past(window_watchdog_halt_reset)))
      else $error("halt reset wrong");

   a_halt_quiet: assert property (@(posedge mclk) disable iff (reset)
      !(halt_entry && window_watchdog_active) |=> !halt_reset)
      else $error("halt reset without cause");

   a_settle_long: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && (s.mem[9] == obd_pkg::SETTLE_CODE_2048)) |=> (osc_settle_half_cycles == obd_pkg::SETTLE_HALF_2048))
      else $error("settle code zero not 2048 cycles");

   a_settle_short: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[4] && (s.mem[9] == obd_pkg::SETTLE_CODE_8)) |=> (osc_settle_half_cycles == obd_pkg::SETTLE_HALF_8))
      else $error("settle code for 8 cycles wrong");

   a_presc_decode: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[3] && (s.mem[7][1:0] == 2'h3)) |=> (wakeup_input_mhz == obd_pkg::WAKEUP_IN_4MHZ))
      else $error("prescaler code 11 wrong");

   a_mismatch: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && (s.mem[5] != ~s.mem[6])) |=> (config_error[2] && !fast_rc_trim_size && !slow_rc_cpu_enable
                                                 && !indep_watchdog_hw_start && !window_watchdog_hw_start))
      else $error("mismatched misc byte applied");

   a_misc_apply: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && (s.mem[5] == ~s.mem[6])) |=> (indep_watchdog_hw_start == $past(s.mem[5][2])
                                                 && fast_rc_trim_size == $past(s.mem[5][4])))
      else $error("misc byte not applied");

   // misc settings: bits 4, 3, 1 and 0 against the stored byte, then the halt bit on a bad pair
   a_trim_apply: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[2]) |=> (fast_rc_trim_size == $past(s.mem[5][4])))
      else $error("trim size bit not applied");

   a_slow_apply: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[2]) |=> (slow_rc_cpu_enable == $past(s.mem[5][3])))
      else $error("slow osc enable bit not applied");

   a_wwd_apply: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[2]) |=> (window_watchdog_hw_start == $past(s.mem[5][1])))
      else $error("window watchdog start bit not applied");

   a_halt_bit: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[2]) |=> (window_watchdog_halt_reset == $past(s.mem[5][0])))
      else $error("halt reset bit not applied");

   a_misc_bad_halt: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && next_s.err[2]) |=> !window_watchdog_halt_reset)
      else $error("mismatched halt reset bit applied");

   // clock settings
   a_ext_clk: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[3]) |=> (external_clock_select == $past(s.mem[7][3])))
      else $error("external clock bit not applied");

   a_wake_sel: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[3]) |=> (wakeup_clock_select == $past(s.mem[7][2])))
      else $error("wakeup clock select not applied");

   a_presc_16: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[3] && !s.mem[7][1]) |=> (wakeup_input_mhz == obd_pkg::WAKEUP_IN_16MHZ))
      else $error("prescaler code 0x wrong");

   a_presc_8: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[3] && (s.mem[7][1:0] == 2'h2)) |=> (wakeup_input_mhz == obd_pkg::WAKEUP_IN_8MHZ))
      else $error("prescaler code 10 wrong");

   a_clk_bad: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && next_s.err[3]) |=> (config_error[3] && !external_clock_select && !wakeup_clock_select
                                     && (wakeup_input_mhz == obd_pkg::WAKEUP_IN_16MHZ)))
      else $error("mismatched clock byte applied");

   // settle wait
   a_settle_128: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[4] && (s.mem[9] == obd_pkg::SETTLE_CODE_128)) |=> (osc_settle_half_cycles == obd_pkg::SETTLE_HALF_128))
      else $error("settle code for 128 cycles wrong");

   a_settle_half: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && !next_s.err[4] && (s.mem[9] == obd_pkg::SETTLE_CODE_HALF)) |=> (osc_settle_half_cycles == obd_pkg::SETTLE_HALF_HALF))
      else $error("settle code for half cycle wrong");

   a_settle_bad: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && next_s.err[4]) |=> (config_error[4] && (osc_settle_half_cycles == obd_pkg::SETTLE_HALF_2048)))
      else $error("mismatched settle byte applied");

   // lock and boot area
   a_lock_stable: assert property (@(posedge mclk) disable iff (reset)
      !opt_we |=> (readout_lock == $past(s.mem[0] == obd_pkg::READOUT_LOCK_CODE)))
      else $error("lock does not follow stored byte");

   a_boot_bad: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && next_s.err[0]) |=> (config_error[0] && (boot_code_area == 8'h00)))
      else $error("mismatched boot byte applied");

   a_boot_debug: assert property (@(posedge mclk) disable iff (reset)
      (opt_we && opt_from_debug && (opt_addr == obd_pkg::OFS_BOOT_AREA_SIZE) && (opt_wdata == ~s.mem[2])
       && (opt_wdata != 8'h00) && (opt_wdata <= obd_pkg::BOOT_MAX_CODE)) |=> (boot_code_area == $past(opt_wdata)))
      else $error("programmed boot byte not applied");

   // pair flags and read port
   a_remap_flag: assert property (@(posedge mclk) disable iff (reset)
      !opt_we |=> (config_error[1] == $past(s.mem[3] != ~s.mem[4])))
      else $error("remap pair flag wrong");

   a_rdata_read: assert property (@(posedge mclk) disable iff (reset)
      (!opt_we && (opt_addr < 4'hB)) |=> (opt_rdata == $past(s.mem[opt_addr])))
      else $error("read data wrong");

   a_rdata_write: assert property (@(posedge mclk) disable iff (reset)
      opt_we |=> (opt_rdata == 8'h00))
      else $error("write cycle returned data");

   // a lone halt cause gives exactly one pulse
   sequence halt_cause;
      halt_entry && window_watchdog_active && window_watchdog_halt_reset;
   endsequence

   sequence halt_pulse;
      halt_reset ##1 !halt_reset;
   endsequence

   a_halt_one: assert property (@(posedge mclk) disable iff (reset)
      (halt_cause ##1 !(halt_entry && window_watchdog_active)) |-> halt_pulse)
      else $error("halt reset pulse length wrong");

endmodule : obd_option_decoder

`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for the option byte decoder
// Assumes: one-cycle write and read latency on the byte port, inputs driven by nba at the rising edge
// Notes:   every wait is a fixed count from the port contract; a run limit guards against a hang
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        mclk;
   logic        reset;
   logic [3:0]  opt_addr;
   logic [7:0]  opt_wdata;
   logic        opt_we;
   logic        opt_from_debug;
   logic [7:0]  opt_rdata;
   logic        halt_entry;
   logic        window_watchdog_active;
   logic        readout_lock;
   logic [7:0]  boot_code_area;
   logic        vectors_protected;
   logic        fast_rc_trim_size;
   logic        slow_rc_cpu_enable;
   logic        indep_watchdog_hw_start;
   logic        window_watchdog_hw_start;
   logic        window_watchdog_halt_reset;
   logic        halt_reset;
   logic        external_clock_select;
   logic        wakeup_clock_select;
   logic [4:0]  wakeup_input_mhz;
   logic [12:0] osc_settle_half_cycles;
   logic [4:0]  config_error;
   int          n_mismatch;
   int          n_compared;

   obd_option_decoder obd_option_decoder_i (.mclk(mclk), .reset(reset), .opt_addr(opt_addr),
      .opt_wdata(opt_wdata), .opt_we(opt_we), .opt_from_debug(opt_from_debug), .opt_rdata(opt_rdata),
      .halt_entry(halt_entry), .window_watchdog_active(window_watchdog_active),
      .readout_lock(readout_lock), .boot_code_area(boot_code_area), .vectors_protected(vectors_protected),
      .fast_rc_trim_size(fast_rc_trim_size), .slow_rc_cpu_enable(slow_rc_cpu_enable),
      .indep_watchdog_hw_start(indep_watchdog_hw_start), .window_watchdog_hw_start(window_watchdog_hw_start),
      .window_watchdog_halt_reset(window_watchdog_halt_reset), .halt_reset(halt_reset),
      .external_clock_select(external_clock_select), .wakeup_clock_select(wakeup_clock_select),
      .wakeup_input_mhz(wakeup_input_mhz), .osc_settle_half_cycles(osc_settle_half_cycles),
      .config_error(config_error));

   // 50 MHz clock, 20 ns period
   always #10 mclk = ~mclk;

   // compare on four-state values so an unknown never matches
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one write; strobe is left high so writes can run back to back
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
      @(posedge mclk);
      opt_we         <= 1'b1;
      opt_addr       <= a;
      opt_wdata      <= d;
      opt_from_debug <= dbg;
   endtask : wr

   // drop the strobe; outputs of the last write are settled after this edge
   task automatic settle();
      @(posedge mclk);
      opt_we <= 1'b0;
      #1;
   endtask : settle

   // plain byte then its complement, back to back
   task automatic wpair(input logic [3:0] a, input logic [7:0] v, input logic dbg);
      wr(a, v, dbg);
      wr(a + 4'h1, ~v, dbg);
      settle();
   endtask : wpair

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      opt_we   <= 1'b0;
      opt_addr <= a;
      @(posedge mclk);
      #1;
      chk("opt_rdata", {5'h00, exp}, {5'h00, opt_rdata});
   endtask : rd

   // halt entry pulse; the reset pulse must last exactly one cycle
   task automatic hlt(input logic act, input logic exp);
      @(posedge mclk);
      halt_entry             <= 1'b1;
      window_watchdog_active <= act;
      @(posedge mclk);
      halt_entry <= 1'b0;
      #1;
      chk("halt_reset", {12'h000, exp}, {12'h000, halt_reset});
      @(posedge mclk);
      #1;
      chk("halt_reset end", 13'h0000, {12'h000, halt_reset});
   endtask : hlt

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   // run limit: far above the length of the sequence
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      $display("BAD run limit expected 0 seen 1");
      wrap_up();
   end

   // main sequence
   initial begin
      logic [7:0] bv [6];
      logic [7:0] pg;
      bv = '{8'h00, 8'h01, 8'h02, 8'h7F, 8'h80, 8'hFF};
      mclk = 1'b0;
      reset = 1'b1;
      opt_addr = 4'h0;
      opt_wdata = 8'h00;
      opt_we = 1'b0;
      opt_from_debug = 1'b0;
      halt_entry = 1'b0;
      window_watchdog_active = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      #1;
      chk("boot_code_area", 13'h0000, {5'h00, boot_code_area});
      chk("settle", 13'h1000, osc_settle_half_cycles);
      chk("config_error", 13'h0000, {8'h00, config_error});
      for (int i = 0; i < 11; i++) rd(i[3:0], (i == 0 || i % 2 == 1) ? 8'h00 : 8'hFF);
      wr(4'hF, 8'h5A, 1'b1);
      settle();
      rd(4'hF, 8'h00);
      $display("test reset done");
      // lock: only the exact code locks, and only from the programming port
      wr(4'h0, 8'hAA, 1'b1);
      settle();
      chk("readout_lock", 13'h0001, {12'h000, readout_lock});
      wr(4'h0, 8'hAB, 1'b1);
      settle();
      chk("readout_lock", 13'h0000, {12'h000, readout_lock});
      wr(4'h0, 8'hAA, 1'b0);
      settle();
      chk("readout_lock", 13'h0000, {12'h000, readout_lock});
      rd(4'h0, 8'hAB);
      $display("test lock done");
      // boot area sizes across the boundaries
      for (int i = 0; i < 6; i++) begin
         pg = (bv[i] > 8'h7F) ? 8'h80 : bv[i];
         wpair(4'h1, bv[i], 1'b1);
         chk("boot_code_area", {5'h00, pg}, {5'h00, boot_code_area});
         chk("vectors_protected", {12'h000, pg >= 8'h02}, {12'h000, vectors_protected});
      end
      wpair(4'h1, 8'h05, 1'b0);
      chk("boot_code_area", 13'h0080, {5'h00, boot_code_area});
      rd(4'h1, 8'hFF);
      wr(4'h1, 8'h05, 1'b1);
      settle();
      chk("config_error", 13'h0001, {8'h00, config_error});
      chk("boot_code_area", 13'h0000, {5'h00, boot_code_area});
      wr(4'h2, 8'hFA, 1'b1);
      settle();
      chk("config_error", 13'h0000, {8'h00, config_error});
      chk("boot_code_area", 13'h0005, {5'h00, boot_code_area});
      $display("test boot done");
      // remap pair: half written flags, whole pair clears
      wr(4'h3, 8'h5A, 1'b0);
      settle();
      chk("config_error", 13'h0002, {8'h00, config_error});
      wr(4'h4, 8'hA5, 1'b0);
      settle();
      chk("config_error", 13'h0000, {8'h00, config_error});
      rd(4'h3, 8'h5A);
      $display("test remap done");
      // each misc bit alone, written by the application
      for (int i = 0; i < 5; i++) begin
         wpair(4'h5, 8'h01 << i, 1'b0);
         chk("misc bits", 13'h0001 << i, {8'h00, fast_rc_trim_size, slow_rc_cpu_enable,
            indep_watchdog_hw_start, window_watchdog_hw_start, window_watchdog_halt_reset});
      end
      wpair(4'h5, 8'h01, 1'b0);
      hlt(1'b1, 1'b1);
      hlt(1'b0, 1'b0);
      wpair(4'h5, 8'h00, 1'b0);
      hlt(1'b1, 1'b0);
      $display("test misc done");
      // every clock option code
      for (int j = 0; j < 16; j++) begin
         wpair(4'h7, j[7:0], 1'b0);
         chk("clock options", {6'h00, j[3], j[2], j[1] ? (j[0] ? 5'h04 : 5'h08) : 5'h10},
            {6'h00, external_clock_select, wakeup_clock_select, wakeup_input_mhz});
      end
      $display("test clock done");
      // settle codes, then a broken pair falls back to the longest wait
      wpair(4'h9, 8'hB4, 1'b0);
      chk("settle", 13'h0100, osc_settle_half_cycles);
      wpair(4'h9, 8'hD2, 1'b0);
      chk("settle", 13'h0010, osc_settle_half_cycles);
      wpair(4'h9, 8'hE1, 1'b0);
      chk("settle", 13'h0001, osc_settle_half_cycles);
      wpair(4'h9, 8'h00, 1'b0);
      chk("settle", 13'h1000, osc_settle_half_cycles);
      wr(4'h9, 8'hB4, 1'b0);
      settle();
      chk("config_error", 13'h0010, {8'h00, config_error});
      chk("settle", 13'h1000, osc_settle_half_cycles);
      rd(4'h9, 8'hB4);
      $display("test settle done");
      wrap_up();
   end
endmodule : tb_top

`default_nettype wire
